// >>> core/cbs_config_bank.sv
// smbus reached configuration register bank of the clock fan-out buffer
// What this block does
// - byte 1 bits 7:6 read back the pll mode caught from the strap.
// - byte 1 bit 5 picks strap pair or software pair as pll mode.
// - software pll mode bits act only while the override bit is one.
// - byte 1 bits 1:0 pick output swing 0.6 to 0.9 volt, default 10.
// - byte 2 bit n sets edge rate of output n, one fast, default ones.
// - byte 3 bit 0 sets feedback edge rate, one fast, default one.
// - byte 3 bit 5 enables software frequency change, default off.
// - frequency bits in byte 3 bits 4:3 act only while bit 5 is one.
// - byte 4 is reserved and always reads all ones.
// - byte 5 is read-only revision code and vendor code.
// - byte 6 is read-only device type and device code.
// - byte 7 bits 4:0 set block read length, reset 8, upper bits zero.
// - block read sends the byte count first, then data bytes in order.
`timescale 1ns/1ps

module cbs_config_bank #(
  parameter logic [3:0] REVISION_CODE = 4'h5, // arbitrary value
  parameter logic [3:0] MAKER_CODE = 4'ha, // arbitrary value
  parameter logic [1:0] PART_TYPE = 2'h3, // arbitrary value
  parameter logic [5:0] PART_CODE = 6'h2a // arbitrary value
) (
  // system side
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // straps, caught after reset release
  input wire logic [1:0] pll_strap_i,
  input wire logic [1:0] bus_address_strap_i,
  // smbus link
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // controls toward pll and drivers
  output logic [1:0] pll_mode_o,
  output logic [1:0] amplitude_o,
  output logic [7:0] edge_rate_o,
  output logic edge_rate_feedback_o,
  output logic freq_sw_active_o,
  output logic [1:0] freq_choice_o
);

  // system clock domain
  logic [1:0] strap_s1_r;
  logic [1:0] strap_s2_r;
  logic [1:0] asel_s1_r;
  logic [1:0] asel_s2_r;
  logic strap_done_r;
  logic latched_pll_sel_hi_r;
  logic latched_pll_sel_lo_r;
  logic [1:0] asel_r;
  logic pll_sel_sw_override_r;
  logic sw_pll_sel_hi_r;
  logic sw_pll_sel_lo_r;
  logic [1:0] amp_r;
  logic [7:0] edge_rate_r;
  logic edge_rate_feedback_r;
  logic freq_en_r;
  logic freq_choice_hi_r;
  logic freq_choice_lo_r;
  logic [4:0] read_len_r;
  logic wr_s1_r;
  logic wr_s2_r;
  logic wr_s3_r;
  logic wr_stb;

  // link clock domain; it has no reset, so toggles and state get
  // power-up values, otherwise they would stay unknown forever
  logic start_tog_r = 1'b0;
  logic start_seen_r = 1'b0;
  cbs_pkg::cbs_state_t st_r = cbs_pkg::ST_IDLE;
  logic [3:0] bit_r;
  logic [7:0] shr_r;
  logic [7:0] idx_r;
  logic [7:0] left_r;
  logic [7:0] wr_idx_r;
  logic [7:0] wr_dat_r;
  logic wr_tog_r = 1'b0;
  logic [39:0] bank_s1_r;
  logic [39:0] bank_s2_r;
  logic [39:0] bank_pub;
  logic sda_oe_r = 1'b0;
  logic new_start;
  logic rx_state;
  logic tx_state;
  logic [7:0] tx_byte;
  logic [6:0] my_addr;

  // strap synchronisers; first stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    strap_s1_r <= pll_strap_i;
    strap_s2_r <= strap_s1_r;
    asel_s1_r <= bus_address_strap_i;
    asel_s2_r <= asel_s1_r;
  end

  // straps caught once, on the first edge after reset release
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      strap_done_r <= 1'b0;
      latched_pll_sel_hi_r <= 1'b0;
      latched_pll_sel_lo_r <= 1'b0;
      asel_r <= 2'h0;
    end
    else if (!strap_done_r)
    begin
      strap_done_r <= 1'b1;
      latched_pll_sel_hi_r <= strap_s2_r[1];
      latched_pll_sel_lo_r <= strap_s2_r[0];
      asel_r <= asel_s2_r;
    end
  end

  // write toggle from the link; index and data are stable for a byte time.
  // not reset: the chain keeps tracking the toggle, so a reset cannot
  // leave a false edge that replays the last write
  always_ff @(posedge clk_i)
  begin
    wr_s1_r <= wr_tog_r;
    wr_s2_r <= wr_s1_r;
    wr_s3_r <= wr_s2_r;
  end

  assign wr_stb = wr_s2_r ^ wr_s3_r;

  // only writable fields are stored; other bits of a write are dropped
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pll_sel_sw_override_r <= cbs_pkg::RST_SW_OVERRIDE;
      {sw_pll_sel_hi_r, sw_pll_sel_lo_r} <= cbs_pkg::RST_SW_PLL_SEL;
      amp_r <= cbs_pkg::RST_AMPLITUDE;
      edge_rate_r <= cbs_pkg::RST_EDGE_RATE;
      edge_rate_feedback_r <= cbs_pkg::RST_EDGE_FB;
      freq_en_r <= cbs_pkg::RST_FREQ_EN;
      {freq_choice_hi_r, freq_choice_lo_r} <= cbs_pkg::RST_FREQ_SEL;
      read_len_r <= cbs_pkg::RST_READ_LEN;
    end
    else if (wr_stb)
    begin
      unique case (wr_idx_r)
        cbs_pkg::IDX_PLL_SWING:
        begin
          pll_sel_sw_override_r <= wr_dat_r[cbs_pkg::POS_OVR];
          sw_pll_sel_hi_r <= wr_dat_r[cbs_pkg::POS_SEL_HI];
          sw_pll_sel_lo_r <= wr_dat_r[cbs_pkg::POS_SEL_LO];
          amp_r <= wr_dat_r[cbs_pkg::POS_AMP_HI:cbs_pkg::POS_AMP_LO];
        end
        cbs_pkg::IDX_EDGE_RATE:
        begin
          edge_rate_r <= wr_dat_r;
        end
        cbs_pkg::IDX_FREQ_SEL:
        begin
          freq_en_r <= wr_dat_r[cbs_pkg::POS_FRQ_EN];
          freq_choice_hi_r <= wr_dat_r[cbs_pkg::POS_FRQ_HI];
          freq_choice_lo_r <= wr_dat_r[cbs_pkg::POS_FRQ_LO];
          edge_rate_feedback_r <= wr_dat_r[cbs_pkg::POS_FB];
        end
        cbs_pkg::IDX_READ_LEN:
        begin
          read_len_r <= wr_dat_r[cbs_pkg::POS_LEN_HI:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  // control outputs, all registered
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pll_mode_o <= 2'h0;
      amplitude_o <= cbs_pkg::RST_AMPLITUDE;
      edge_rate_o <= cbs_pkg::RST_EDGE_RATE;
      edge_rate_feedback_o <= cbs_pkg::RST_EDGE_FB;
      freq_sw_active_o <= cbs_pkg::RST_FREQ_EN;
      freq_choice_o <= 2'h0;
    end
    else
    begin
      if (pll_sel_sw_override_r)
        pll_mode_o <= {sw_pll_sel_hi_r, sw_pll_sel_lo_r};
      else
        pll_mode_o <= {latched_pll_sel_hi_r, latched_pll_sel_lo_r};
      amplitude_o <= amp_r;
      edge_rate_o <= edge_rate_r;
      edge_rate_feedback_o <= edge_rate_feedback_r;
      freq_sw_active_o <= freq_en_r;
      // choice held at zero while software change is disabled
      freq_choice_o <= freq_en_r ?
        {freq_choice_hi_r, freq_choice_lo_r} : 2'h0;
    end
  end

  // published view of the bank for the link side; quasi-static, it only
  // moves at reset, at the strap capture or after a host write, long before the host can read it back
  assign bank_pub = {asel_r,
                     latched_pll_sel_hi_r, latched_pll_sel_lo_r,
                     pll_sel_sw_override_r, sw_pll_sel_hi_r,
                     sw_pll_sel_lo_r, amp_r,
                     edge_rate_r,
                     freq_en_r, freq_choice_hi_r, freq_choice_lo_r,
                     edge_rate_feedback_r,
                     read_len_r,
                     14'h0000};

  // link logic
  // start seen as sda falling while scl is high
  always_ff @(negedge sda_i)
  begin
    if (scl_i)
      start_tog_r <= ~start_tog_r;
  end

  always_ff @(posedge scl_i)
  begin
    bank_s1_r <= bank_pub;
    bank_s2_r <= bank_s1_r;
  end

  function automatic logic [6:0] addr_of(input logic [1:0] sel);
    unique case (sel)
      2'h0: addr_of = cbs_pkg::ADDR_STRAP0;
      2'h1: addr_of = cbs_pkg::ADDR_STRAP1;
      default: addr_of = cbs_pkg::ADDR_STRAP2;
    endcase
  endfunction

  function automatic logic [7:0] read_byte(input logic [7:0] idx,
                                           input logic [39:0] bk);
    unique case (idx)
      cbs_pkg::IDX_PLL_SWING:
        read_byte = {bk[37:36], bk[35:33], 1'b1, bk[32:31]};
      cbs_pkg::IDX_EDGE_RATE:
        read_byte = bk[30:23];
      cbs_pkg::IDX_FREQ_SEL:
        read_byte = {2'h3, bk[22:20], 2'h3, bk[19]};
      cbs_pkg::IDX_RSVD_ONES:
        read_byte = cbs_pkg::RSVD_ONES;
      cbs_pkg::IDX_REV_VENDOR:
        read_byte = {REVISION_CODE, MAKER_CODE};
      cbs_pkg::IDX_PART_TYPE:
        read_byte = {PART_TYPE, PART_CODE};
      cbs_pkg::IDX_READ_LEN:
        read_byte = {cbs_pkg::READ_LEN_PAD, bk[18:14]};
      default:
        read_byte = cbs_pkg::UNMAPPED_VAL;
    endcase
  endfunction

  assign my_addr = addr_of(bank_s2_r[39:38]);
  assign new_start = start_tog_r ^ start_seen_r;
  assign rx_state = (st_r == cbs_pkg::ST_ADDR) ||
                    (st_r == cbs_pkg::ST_INDEX) ||
                    (st_r == cbs_pkg::ST_COUNT) ||
                    (st_r == cbs_pkg::ST_WDATA);
  assign tx_state = (st_r == cbs_pkg::ST_RCOUNT) ||
                    (st_r == cbs_pkg::ST_RDATA);
  assign tx_byte = (st_r == cbs_pkg::ST_RCOUNT) ?
                   {cbs_pkg::READ_LEN_PAD, bank_s2_r[18:14]} :
                   read_byte(idx_r, bank_s2_r);

  // byte engine, sampling sda on the rising scl edge
  always_ff @(posedge scl_i)
  begin
    start_seen_r <= start_tog_r;
    if (new_start)
    begin
      // first rising edge after a start already carries address bit 7
      st_r <= cbs_pkg::ST_ADDR;
      shr_r <= {shr_r[6:0], sda_i};
      bit_r <= 4'h1;
    end
    else if (rx_state && bit_r != cbs_pkg::BITS_PER_BYTE)
    begin
      shr_r <= {shr_r[6:0], sda_i};
      bit_r <= bit_r + 4'h1;
    end
    else if (rx_state)
    begin
      // ack clock: act on the finished byte
      bit_r <= 4'h0;
      unique case (st_r)
        cbs_pkg::ST_ADDR:
        begin
          if (shr_r[7:1] != my_addr)
            st_r <= cbs_pkg::ST_IDLE;
          else if (shr_r[0])
          begin
            st_r <= cbs_pkg::ST_RCOUNT;
            left_r <= {3'h0, bank_s2_r[18:14]};
          end
          else
            st_r <= cbs_pkg::ST_INDEX;
        end
        cbs_pkg::ST_INDEX:
        begin
          idx_r <= shr_r;
          st_r <= cbs_pkg::ST_COUNT;
        end
        cbs_pkg::ST_COUNT:
        begin
          left_r <= shr_r;
          st_r <= (shr_r == 8'h00) ? cbs_pkg::ST_IDLE : cbs_pkg::ST_WDATA;
        end
        default:
        begin
          wr_idx_r <= idx_r;
          wr_dat_r <= shr_r;
          wr_tog_r <= ~wr_tog_r;
          idx_r <= idx_r + 8'h01;
          left_r <= left_r - 8'h01;
          if (left_r == 8'h01)
            st_r <= cbs_pkg::ST_IDLE;
        end
      endcase
    end
    else if (tx_state && bit_r != cbs_pkg::BITS_PER_BYTE)
      bit_r <= bit_r + 4'h1;
    else if (tx_state)
    begin
      // host ack clock: nack or exhausted count ends the read
      bit_r <= 4'h0;
      if (st_r == cbs_pkg::ST_RDATA)
        idx_r <= idx_r + 8'h01;
      if (sda_i || left_r == 8'h00)
        st_r <= cbs_pkg::ST_IDLE;
      else
      begin
        st_r <= cbs_pkg::ST_RDATA;
        left_r <= left_r - 8'h01;
      end
    end
  end

  // sda is driven only on the falling scl edge, so it never moves while
  // scl is high and cannot fake a start or stop
  always_ff @(negedge scl_i)
  begin
    if (rx_state && bit_r == cbs_pkg::BITS_PER_BYTE)
      sda_oe_r <= (st_r != cbs_pkg::ST_ADDR) ||
                  (shr_r[7:1] == my_addr);
    else if (tx_state && bit_r != cbs_pkg::BITS_PER_BYTE)
      sda_oe_r <= ~tx_byte[3'h7 - bit_r[2:0]];
    else
      sda_oe_r <= 1'b0;
  end

  assign sda_oe_o = sda_oe_r;
  assign sda_o = 1'b0;

endmodule

// >>> core/cbs_pkg.sv
// constants and types for the clock buffer smbus configuration bank
package cbs_pkg;

  // register indices
  localparam logic [7:0] IDX_PLL_SWING = 8'h01;
  localparam logic [7:0] IDX_EDGE_RATE = 8'h02;
  localparam logic [7:0] IDX_FREQ_SEL = 8'h03;
  localparam logic [7:0] IDX_RSVD_ONES = 8'h04;
  localparam logic [7:0] IDX_REV_VENDOR = 8'h05;
  localparam logic [7:0] IDX_PART_TYPE = 8'h06;
  localparam logic [7:0] IDX_READ_LEN = 8'h07;

  // reset values of writable fields
  localparam logic RST_SW_OVERRIDE = 1'b0;
  localparam logic [1:0] RST_SW_PLL_SEL = 2'h0;
  localparam logic [1:0] RST_AMPLITUDE = 2'h2;
  localparam logic [7:0] RST_EDGE_RATE = 8'hff;
  localparam logic RST_EDGE_FB = 1'b1;
  localparam logic RST_FREQ_EN = 1'b0;
  localparam logic [1:0] RST_FREQ_SEL = 2'h0;
  localparam logic [4:0] RST_READ_LEN = 5'h08;

  // fixed read values
  localparam logic [7:0] RSVD_ONES = 8'hff;
  localparam logic [7:0] UNMAPPED_VAL = 8'h00;
  localparam logic [2:0] READ_LEN_PAD = 3'h0;

  // field positions in the received byte
  localparam int POS_OVR = 5;
  localparam int POS_SEL_HI = 4;
  localparam int POS_SEL_LO = 3;
  localparam int POS_AMP_HI = 1;
  localparam int POS_AMP_LO = 0;
  localparam int POS_FRQ_EN = 5;
  localparam int POS_FRQ_HI = 4;
  localparam int POS_FRQ_LO = 3;
  localparam int POS_FB = 0;
  localparam int POS_LEN_HI = 4;

  // bus address chosen by the address strap
  localparam logic [6:0] ADDR_STRAP0 = 7'h6b;
  localparam logic [6:0] ADDR_STRAP1 = 7'h6c;
  localparam logic [6:0] ADDR_STRAP2 = 7'h6d;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_INDEX = 3'b010,
    ST_COUNT = 3'b011,
    ST_WDATA = 3'b100,
    ST_RCOUNT = 3'b101,
    ST_RDATA = 3'b110
  } cbs_state_t;

endpackage

// >>> tb/cbs_config_bank_props.sv
// assertions on the configuration bank ports
`timescale 1ns/1ps
module cbs_config_bank_props (
  // system side
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [1:0] pll_strap_i,
  input wire logic [1:0] bus_address_strap_i,
  // smbus link
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // controls
  input wire logic [1:0] pll_mode_o,
  input wire logic [1:0] amplitude_o,
  input wire logic [7:0] edge_rate_o,
  input wire logic edge_rate_feedback_o,
  input wire logic freq_sw_active_o,
  input wire logic [1:0] freq_choice_o
);
  logic [2:0] scl_s_r;
  logic [7:0] quiet_r;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // cycles since scl last rose; settings only move while the link runs
  always_ff @(posedge clk_i)
  begin
    scl_s_r <= {scl_s_r[1:0], scl_i};
  end
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      quiet_r <= 8'hff;
    else if (scl_s_r[2:1] == 2'b01)
      quiet_r <= 8'h00;
    else if (quiet_r != 8'hff)
      quiet_r <= quiet_r + 8'h01;
  end
  sequence s_release;
    $fell(sys_rst_i);
  endsequence
  sequence s_settled;
    !$past(sys_rst_i) ##0 quiet_r > 8'h08;
  endsequence
  a_reset_swing: assert property (s_release |-> amplitude_o == 2'h2)
    else $error("swing not at reset value");
  a_reset_edges: assert property (s_release |->
    edge_rate_o == 8'hff && edge_rate_feedback_o)
    else $error("edge rates not at reset value");
  a_reset_freq: assert property (s_release |-> !freq_sw_active_o)
    else $error("frequency change enabled at reset");
  a_strap_mode: assert property (s_release |-> ##2
    pll_mode_o == $past(pll_strap_i, 2)) else $error("strap mode wrong");
  a_freq_gated: assert property (!freq_sw_active_o |->
    freq_choice_o == 2'h0) else $error("frequency bits act while off");
  a_quiet_swing: assert property (s_settled |->
    $stable(amplitude_o)) else $error("swing moved without link activity");
  a_quiet_edges: assert property (s_settled |->
    $stable(edge_rate_o))
    else $error("edge rates moved without link activity");
  a_quiet_mode: assert property (s_settled ##0
    !$past(sys_rst_i, 3) |-> $stable(pll_mode_o))
    else $error("pll mode moved without activity");
endmodule

bind cbs_config_bank cbs_config_bank_props u_props (.clk_i, .sys_rst_i,
  .pll_strap_i, .bus_address_strap_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
  .pll_mode_o, .amplitude_o, .edge_rate_o, .edge_rate_feedback_o,
  .freq_sw_active_o, .freq_choice_o);

// >>> tb/cbs_config_bank_tb.sv
// self-checking bench for the configuration bank
`timescale 1ns/1ps
`define CHK(n, e, g) \
  compares++; \
  if ((g) !== (e)) \
  begin \
    fail_count++; \
    $display("Error %s expected %h seen %h", n, e, g); \
  end
module cbs_config_bank_tb;
  localparam logic [3:0] REV = 4'h3; // arbitrary value
  localparam logic [3:0] MAKER = 4'hc; // arbitrary value
  localparam logic [1:0] PTYPE = 2'h2; // arbitrary value
  localparam logic [5:0] PCODE = 6'h15; // arbitrary value
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [1:0] strap = 2'h1;
  logic scl, host_sda, sda_o, sda_oe_o, fb, frq_en, ok;
  wire logic sda_w;
  logic [1:0] mode, amp, frq;
  logic [7:0] edge_rate, cnt;
  logic [7:0] q [8];
  logic [7:0] d [8];
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  // pull-up wire; an undriven enable counts as released
  assign sda_w = host_sda & (sda_oe_o === 1'b1 ? sda_o : 1'b1);
  cbs_config_bank #(.REVISION_CODE(REV), .MAKER_CODE(MAKER),
    .PART_TYPE(PTYPE), .PART_CODE(PCODE)) uut (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .pll_strap_i(strap),
    .bus_address_strap_i(2'h0), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .pll_mode_o(mode),
    .amplitude_o(amp), .edge_rate_o(edge_rate),
    .edge_rate_feedback_o(fb), .freq_sw_active_o(frq_en),
    .freq_choice_o(frq));
  cbs_host host (.scl_o(scl), .sda_o(host_sda), .sda_i(sda_w));
  initial
  begin
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end
  task stop_test;
    if (fail_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task settle;
    repeat (8) @(posedge clk_i);
    #1;
  endtask
  task wr1(input logic [7:0] idx, input logic [7:0] v);
    d[0] = v;
    host.wr(idx, 1, d, ok);
    `CHK("ack", 1'b1, ok)
    settle();
  endtask
  task t_reset;
    logic [7:0] e [7];
    e = '{{strap, 6'h06}, 8'hff, 8'hc7, 8'hff, {REV, MAKER},
      {PTYPE, PCODE}, 8'h08};
    @(posedge clk_i);
    #1 sys_rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    repeat (4) settle();
    `CHK("amp", 2'h2, amp)
    `CHK("edge", 8'hff, edge_rate)
    `CHK("fb", 1'b1, fb)
    `CHK("frq_en", 1'b0, frq_en)
    `CHK("mode", strap, mode)
    host.rd(8'h01, 7, cnt, q, ok);
    `CHK("len", 8'h08, cnt)
    for (int i = 0; i < 7; i++)
    begin
      `CHK("rd", e[i], q[i])
    end
  endtask
  task t_block;
    d = '{8'hfd, 8'h5a, 8'h00, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
    host.wr(8'h01, 3, d, ok);
    settle();
    `CHK("mode", 2'h3, mode)
    `CHK("edge", 8'h5a, edge_rate)
    `CHK("fb", 1'b0, fb)
    host.rd(8'h01, 3, cnt, q, ok);
    `CHK("b1", {strap, 6'h3d}, q[0])
    `CHK("b3", 8'hc6, q[2])
  endtask
  task t_amp;
    for (int a = 0; a < 4; a++)
    begin
      wr1(8'h01, {6'h10, a[1:0]});
      `CHK("amp", a[1:0], amp)
      `CHK("mode", strap, mode)
    end
  endtask
  task t_freq;
    wr1(8'h03, 8'h18);
    `CHK("frq", 2'h0, frq)
    wr1(8'h03, 8'h39);
    `CHK("frq_en", 1'b1, frq_en)
    `CHK("frq", 2'h3, frq)
  endtask
  task t_ro;
    d = '{8'h00, 8'h00, 8'h00, 8'he3, 8'h0, 8'h0, 8'h0, 8'h0};
    host.wr(8'h04, 4, d, ok);
    host.rd(8'h04, 3, cnt, q, ok);
    `CHK("len", 8'h03, cnt)
    `CHK("b4", 8'hff, q[0])
    `CHK("b5", {REV, MAKER}, q[1])
    `CHK("b6", {PTYPE, PCODE}, q[2])
  endtask
  task t_bad;
    host.addr = 7'h6c;
    d[0] = 8'h00;
    host.wr(8'h01, 1, d, ok);
    settle();
    `CHK("nack", 1'b0, ok)
    `CHK("amp", 2'h3, amp)
    host.addr = 7'h6b;
  endtask
  initial
  begin
    t_reset();
    t_block();
    t_amp();
    t_freq();
    t_ro();
    t_bad();
    t_reset();
    stop_test();
  end
endmodule

// >>> tb/cbs_host.sv
// smbus host model issuing block writes and reads
`timescale 1ns/1ps
module cbs_host (
  // smbus wires, data released means high
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  logic [6:0] addr = 7'h6b;
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task bit_out(input logic b);
    sda_o = b;
    #16 scl_o = 1'b1;
    #32 scl_o = 1'b0;
    #16;
  endtask
  task bit_in(output logic b);
    sda_o = 1'b1;
    #16 scl_o = 1'b1;
    #16 b = sda_i;
    #16 scl_o = 1'b0;
    #16;
  endtask
  task start;
    sda_o = 1'b1;
    #16 scl_o = 1'b1;
    #32 sda_o = 1'b0;
    #32 scl_o = 1'b0;
    #16;
  endtask
  // scl stands high between frames
  task stop;
    sda_o = 1'b0;
    #16 scl_o = 1'b1;
    #32 sda_o = 1'b1;
    #32;
  endtask
  task put(input logic [7:0] v, inout logic ok);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_out(v[i]);
    bit_in(a);
    ok = ok & !a;
  endtask
  task get(output logic [7:0] v, input logic last);
    for (int i = 7; i >= 0; i--)
      bit_in(v[i]);
    bit_out(last);
  endtask
  task wr(input logic [7:0] idx, input int n, input logic [7:0] d [8],
    output logic ok);
    ok = 1'b1;
    start();
    put({addr, 1'b0}, ok);
    put(idx, ok);
    put(n[7:0], ok);
    for (int i = 0; i < n; i++)
      put(d[i], ok);
    stop();
  endtask
  task rd(input logic [7:0] idx, input int n, output logic [7:0] cnt,
    output logic [7:0] q [8], output logic ok);
    ok = 1'b1;
    start();
    put({addr, 1'b0}, ok);
    put(idx, ok);
    start();
    put({addr, 1'b1}, ok);
    get(cnt, 1'b0);
    for (int i = 0; i < n; i++)
      get(q[i], i == n - 1);
    stop();
  endtask
endmodule
